// [rtl/motion_cmd_pkg.sv]
// Package: command codes, argument formats and shared types
package motion_cmd_pkg;
  // ==========================================================================
  // Axis mask and argument widths
  localparam int AXES        = 4;
  localparam int MASK_W      = 8;
  localparam int ACC_W       = 16;
  localparam int ACC_FRAC    = 15;
  localparam int POS_W       = 32;
  localparam int VEL_W       = 32;
  localparam int VEL_SIG_W   = 27;
  localparam int VEL_FRAC    = 16;
  localparam int BYTE_W      = 8;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CODE_HALT_DECEL = 8'h86;
  localparam logic [7:0] CODE_AXIS_MOVE  = 8'h60;

  // Reset value of the stored halting deceleration (one count per interval squared)
  localparam logic [ACC_W-1:0] HALT_DECEL_RESET = 16'h8000;

  // One byte of the command window as seen by the poller
  typedef struct packed {
    logic             valid;
    logic             is_code;
    logic [BYTE_W-1:0] data;
  } cmd_byte_t;

  // Stop request from the fault paths
  typedef struct packed {
    logic ferr_halt;
    logic emergency_stop_input;
    logic probe;
    logic input_abort;
  } stop_cause_t;
endpackage

// [rtl/axis_halt_stop.sv]
// Per-axis halting deceleration store and stop ramp
`timescale 1ns/1ps
module axis_halt_stop
  import motion_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Limit update
  input  wire logic             load,
  input  wire logic [ACC_W-1:0] decel_in,
  // Stop request and velocity
  input  wire logic             stop_req,
  input  wire logic [VEL_W-1:0] vel_in,
  // Results
  output logic      [ACC_W-1:0] decel,
  output logic                  halting,
  output logic      [VEL_W-1:0] vel_out
);
  // Decel zero-extended with no shift: its 1.15 bits taken as 16.16 velocity units, half the limit per interval
  wire logic [VEL_W-1:0] step = {{(VEL_W-ACC_W){1'b0}}, decel} >> (ACC_FRAC - VEL_FRAC + 1);
  wire logic             neg  = vel_out[VEL_W-1];
  wire logic [VEL_W-1:0] mag  = neg ? (~vel_out + 32'h0000_0001) : vel_out;
  wire logic [VEL_W-1:0] next_mag = (mag > step) ? (mag - step) : '0;
  wire logic [VEL_W-1:0] next_vel = neg ? (~next_mag + 32'h0000_0001) : next_mag;

  // ==========================================================================
  // Limit register; zero argument was filtered upstream
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      decel <= HALT_DECEL_RESET;
    end else if (load) begin
      decel <= decel_in;
    end
  end

  // ==========================================================================
  // Halting ramp uses stored limit
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      halting <= 1'b0;
      vel_out <= '0;
    end else if (stop_req) begin
      halting <= 1'b1;
      vel_out <= vel_in;
    end else if (halting) begin
      vel_out <= next_vel;
      halting <= (next_mag != '0);
    end else begin
      vel_out <= vel_in;
    end
  end

  ramp_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (halting && !stop_req && !$past(stop_req)) |=> (mag <= $past(mag)))
    else $error("halt ramp grew in magnitude");
endmodule // axis_halt_stop

// [rtl/motion_cmd_decoder.sv]
// Command window decoder with halting deceleration command
`timescale 1ns/1ps

// Contract
// - Axis byte: low four bits select axes
// - Acceleration is unsigned 1.15 fixed point
// - Position, error are 32-bit signed integers
// - Velocity 27-bit signed, extended, 16.16
// - Halt-decel code stores limit per axis
// - Stored limit drives fault stop ramps
// - Zero deceleration argument is ignored
// - Act on each command when read
// - New command overrides unfinished earlier ones
module motion_cmd_decoder
  import motion_cmd_pkg::*;
#(
  parameter int N_AXES = AXES
)(
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  // Command window bytes from the poller
  input  motion_cmd_pkg::cmd_byte_t          cmd_in,
  // Stop causes and per-axis live velocity
  input  motion_cmd_pkg::stop_cause_t        stop_cause,
  input  wire logic [N_AXES-1:0]             axis_stop,
  input  wire logic [N_AXES*VEL_W-1:0]       axis_vel,
  // Results
  output logic      [N_AXES*ACC_W-1:0]       halt_decel,
  output logic      [N_AXES-1:0]             axis_halting,
  output logic      [N_AXES*VEL_W-1:0]       axis_vel_cmd,
  output logic                               cmd_done,
  output logic      [N_AXES-1:0]             cmd_axes
);
  import motion_cmd_pkg::*;

  // ==========================================================================
  // Elaboration checks; the mask byte only carries four axis bits
  if (N_AXES != AXES) begin : g_bad_axes
    $error("axis count must match the mask width");
  end
  // Position and error words are whole counts
  if (POS_W != VEL_W) begin : g_bad_pos
    $error("position word width must match the velocity word");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MASK = 2'b01,
    ST_LO   = 2'b10,
    ST_HI   = 2'b11
  } dec_state_t;

  dec_state_t          state;
  logic [N_AXES-1:0]   pending;
  logic [BYTE_W-1:0]   lo_byte;
  logic [N_AXES-1:0]   load;
  logic [ACC_W-1:0]    load_val;

  // ==========================================================================
  // Byte decode
  wire logic new_code  = cmd_in.valid && cmd_in.is_code;
  wire logic arg_byte  = cmd_in.valid && !cmd_in.is_code;
  wire logic is_halt   = cmd_in.data == CODE_HALT_DECEL;
  wire logic [N_AXES-1:0] mask_sel = cmd_in.data[N_AXES-1:0];
  // Lowest pending axis takes next group
  wire logic [N_AXES-1:0] cur_axis = pending & (~pending + 1'b1);
  wire logic [N_AXES-1:0] rest     = pending & ~cur_axis;
  wire logic [ACC_W-1:0]  acc_word = {cmd_in.data, lo_byte};
  wire logic              acc_ok   = acc_word != '0;
  wire logic [N_AXES-1:0] any_stop = axis_stop | {N_AXES{|stop_cause}};
  // Last high byte of a halt command
  wire logic              last_hi  = arg_byte && state == ST_HI && rest == '0;

  // ==========================================================================
  // Decoder steps on every byte read
  // A fresh code always clears pending; only the halt code restarts decode, others return to idle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state   <= ST_IDLE;
      pending <= '0;
      lo_byte <= '0;
    end else if (new_code) begin
      state   <= is_halt ? ST_MASK : ST_IDLE;
      pending <= '0;
    end else if (arg_byte) begin
      unique case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_MASK: begin
          pending <= mask_sel;
          state   <= (mask_sel != '0) ? ST_LO : ST_IDLE;
        end
        ST_LO: begin
          lo_byte <= cmd_in.data;
          state   <= ST_HI;
        end
        ST_HI: begin
          pending <= rest;
          state   <= (rest != '0) ? ST_LO : ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Load limit on selected axis
  always_comb begin
    load     = '0;
    load_val = acc_word;
    if (arg_byte && state == ST_HI && acc_ok) begin
      load = cur_axis;
    end
  end

  // Completion pulse registered for the host side view
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmd_done <= 1'b0;
      cmd_axes <= '0;
    end else begin
      cmd_done <= arg_byte && state == ST_HI && rest == '0;
      cmd_axes <= (arg_byte && state == ST_MASK) ? mask_sel : cmd_axes;
    end
  end

  // ==========================================================================
  // One stop unit per axis
  for (genvar a = 0; a < N_AXES; a++) begin : g_axis
    axis_halt_stop u_stop (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .load     (load[a]),
      .decel_in (load_val),
      .stop_req (any_stop[a]),
      .vel_in   (axis_vel[a*VEL_W +: VEL_W]),
      .decel    (halt_decel[a*ACC_W +: ACC_W]),
      .halting  (axis_halting[a]),
      .vel_out  (axis_vel_cmd[a*VEL_W +: VEL_W])
    );
  end

  limit_store_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (arg_byte && state == ST_HI && acc_ok && cur_axis[0] && !new_code)
      |=> (halt_decel[ACC_W-1:0] == $past(acc_word)))
    else $error("halt limit not stored");
  zero_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (arg_byte && state == ST_HI && !acc_ok) |=> $stable(halt_decel))
    else $error("zero limit was stored");
  mask_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (arg_byte && state == ST_MASK && !new_code) |=> (pending == $past(mask_sel)))
    else $error("mask decode wrong");
  code_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    new_code |=> (pending == '0))
    else $error("new code did not restart");
  axis_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (arg_byte && state == ST_HI && !new_code) |=> (pending == ($past(pending) & ($past(pending) - 1'b1))))
    else $error("axis groups out of order");
  stop_act_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stop_cause.emergency_stop_input |=> (axis_halting == '1))
    else $error("stop not acted on");
  halt_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!axis_halting[0] && !any_stop[0]) |=> !axis_halting[0])
    else $error("halting rose without cause");
  idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state == ST_IDLE) |=> $stable(halt_decel))
    else $error("limit changed while idle");

  // ==========================================================================
  // Decode sequencing and output checks
  // Completion follows last byte
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    last_hi |=> cmd_done)
    else $error("completion pulse missing");

  done_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cmd_done |=> !cmd_done)
    else $error("completion pulse too long");

  axes_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (arg_byte && state == ST_MASK) |=> (cmd_axes == $past(mask_sel)))
    else $error("reported axes wrong");

  mask_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (arg_byte && state == ST_MASK && mask_sel == '0) |=> (state == ST_IDLE))
    else $error("empty mask kept decoding");

  arg_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (arg_byte && state == ST_IDLE) |=> (state == ST_IDLE))
    else $error("stray argument left idle");

  other_code_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (new_code && !is_halt) |=> (state == ST_IDLE))
    else $error("foreign code started decode");

  load_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $onehot0(load))
    else $error("several axes loaded at once");

  vel_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!any_stop[0] && !axis_halting[0]) |=> (axis_vel_cmd[VEL_W-1:0] == $past(axis_vel[VEL_W-1:0])))
    else $error("velocity not passed through");

  halt_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    any_stop[0] |=> axis_halting[0])
    else $error("stop request ignored");
endmodule // motion_cmd_decoder

// [tb/host_cmd_model.sv]
// Host model that writes commands into the command window
`timescale 1ns/1ps
module host_cmd_model
  import motion_cmd_pkg::*;
(
  // Clock
  input  wire logic                ref_clk,
  // Command window bytes
  output motion_cmd_pkg::cmd_byte_t cmd_in
);
  initial cmd_in = '0;

  // ==========================================================================
  // Byte writer, one byte per cycle
  task automatic put(input logic code, input logic [7:0] b);
    @(negedge ref_clk);
    cmd_in <= '{1'b1, code, b};
  endtask

  // Released window shows the inverse, never a stale byte
  task automatic idle();
    @(negedge ref_clk);
    cmd_in <= '{1'b0, 1'b0, ~cmd_in.data};
  endtask

  // ==========================================================================
  // Whole halt command: code, mask, then low and high byte per selected axis
  // syntax order, ascending axes
  task automatic send(input logic [7:0] mask, input logic [63:0] w);
    put(1'b1, CODE_HALT_DECEL);
    put(1'b0, mask);
    for (int a = 0; a < 4; a++) begin
      if (mask[a]) begin
        put(1'b0, w[16*a +: 8]);
        put(1'b0, w[16*a+8 +: 8]);
      end
    end
    idle();
  endtask
endmodule // host_cmd_model

// [tb/motion_cmd_decoder_tb.sv]
// Self-checking testbench for the command decoder
`timescale 1ns/1ps
module motion_cmd_decoder_tb;
  import motion_cmd_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  cmd_byte_t    cmd_in;
  stop_cause_t  stop_cause = '0;
  logic [3:0]   axis_stop = '0;
  logic [127:0] axis_vel = '0;
  logic [63:0]  halt_decel;
  logic [3:0]   axis_halting;
  logic [127:0] axis_vel_cmd;
  logic         cmd_done;
  logic [3:0]   cmd_axes;
  int           n_errors = 0;
  int           n_compared = 0;

  // ==========================================================================
  // Design and host model
  motion_cmd_decoder motion_cmd_decoder_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmd_in(cmd_in), .stop_cause(stop_cause), .axis_stop(axis_stop),
    .axis_vel(axis_vel), .halt_decel(halt_decel), .axis_halting(axis_halting),
    .axis_vel_cmd(axis_vel_cmd), .cmd_done(cmd_done), .cmd_axes(cmd_axes));
  host_cmd_model host_cmd_model_i (.ref_clk(ref_clk), .cmd_in(cmd_in));

  // Free-running clock
  initial forever #2 ref_clk = ~ref_clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait on a flag, sampled after the edge settles
  task automatic wait_hi(ref logic f, input int lim);
    for (int i = 0; i < lim && f !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic cmd_case(input logic [7:0] m, input logic [63:0] w,
                          input logic [63:0] exp, input logic [3:0] ax);
    host_cmd_model_i.send(m, w);
    wait_hi(cmd_done, 6);
    check(cmd_done, 1'b1);
    check(halt_decel, exp);
    check(cmd_axes, ax);
  endtask

  task automatic t_stop();
    @(negedge ref_clk);
    axis_vel[31:0] = 32'h0001_0000;
    axis_stop[0] = 1'b1;
    for (int i = 0; i < 4 && axis_halting[0] !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check(axis_vel_cmd[31:0], 32'h0001_0000);
    // Drop the request so the ramp can run
    @(negedge ref_clk);
    axis_stop[0] = 1'b0;
    @(posedge ref_clk);
    #1;
    check(axis_vel_cmd[31:0], 32'h0001_0000 - 32'h1234);
    for (int i = 0; i < 40 && axis_halting[0] !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check(axis_vel_cmd[31:0], 32'h0);
  endtask

  task automatic t_causes();
    for (int c = 0; c < 4; c++) begin
      @(negedge ref_clk);
      axis_vel = {4{32'h0000_8000}};
      stop_cause = stop_cause_t'(4'h1 << c);
      for (int i = 0; i < 4 && axis_halting !== 4'hf; i++) begin
        @(posedge ref_clk);
        #1;
      end
      check(axis_halting, 4'hf);
      @(negedge ref_clk);
      stop_cause = '0;
      repeat (20) @(posedge ref_clk);
    end
  endtask

  // ==========================================================================
  // Verdict and hang guard
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    #1;
    check(halt_decel, {4{16'h8000}});
    cmd_case(8'h06, 64'h0000_4000_4000_0000, 64'h8000_4000_4000_8000, 4'h6);
    cmd_case(8'hf9, 64'hffff_0000_0000_1234, 64'hffff_4000_4000_1234, 4'h9);
    cmd_case(8'h03, 64'h0000_0000_7000_0000, 64'hffff_4000_7000_1234, 4'h3);
    // Half-sent command cut short by a fresh code
    host_cmd_model_i.put(1'b1, CODE_HALT_DECEL);
    host_cmd_model_i.put(1'b0, 8'h01);
    host_cmd_model_i.put(1'b0, 8'h55);
    cmd_case(8'h08, 64'h2222_0000_0000_0000, 64'h2222_4000_7000_1234, 4'h8);
    t_stop();
    t_causes();
    conclude();
  end
endmodule // motion_cmd_decoder_tb
